// File: inc/pmx_pkg.sv
/*
  Constants and types for the port pin function multiplexer: register offsets,
  writable masks, reset values, per-pin legal select codes and state structs.
  Assumes offsets are byte offsets from the system register base.
*/
// Behaviour
// R1: Port 0 select register at offset 0x00, resets to 0x0000_0003.
// R2: Port 1 select register at offset 0x04, resets to zero.
// R3: Port 2 select register at offset 0x08, read/write, resets to zero.
// R4: Write-protection control register at offset 0x40, read/write, resets to zero.
// R5: Pin n uses bit 16+n extension, 8+n middle, n low; bits 31:24 reserved.
// R6: Pin code is {extension, middle, low}; code 000 always selects GPIO.
// R7: Port 0 pin 1: debug data, UART2 tx, I2C data, SPI1 select; 111 reserved.
// R8: Port 0 pin 0: debug clock, UART2 rx, I2C clock, SPI1 clock; 111 reserved.
// R9: Only port 0 pins 0 and 1 select; low bits 7:2 reserved.
// R10: Port 1 pin 5: SPI1 select, PWM5, timer input, UART1 rx; 111 reserved.
// R11: Port 1 pin 4: UART1 CTS, I2C clock, PWM2, code 110 SPI1 clock.
// R12: Port 1 pin 3: UART1 RTS, I2C data, PWM3, SPI2 select, SPI1 select.
// R13: Port 1 pin 2: UART1 rx, PWM4, timer out, UART2 tx, SPI1 slave-out.
// R14: Port 1 pin 1: UART2 RTS, SPI1 master-out, PWM7, slow clock, UART1 tx.
// R15: Port 1 pin 0 and low bits 7:6 have no selection; reserved.
// R16: Reserved bits read zero; reserved or unlisted codes behave as GPIO.
// R17: New code routes the cycle after the write, other pins untouched.
package pmx_pkg;

  localparam int PMX_PINS   = 16;
  localparam int PMX_CODES  = 8;
  localparam int PMX_ADDR_W = 8;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [PMX_ADDR_W-1:0] PMX_OFF_P0   = 8'h00;
  localparam logic [PMX_ADDR_W-1:0] PMX_OFF_P1   = 8'h04;
  localparam logic [PMX_ADDR_W-1:0] PMX_OFF_P2   = 8'h08;
  localparam logic [PMX_ADDR_W-1:0] PMX_OFF_WPC  = 8'h40;
  localparam logic [PMX_ADDR_W-1:0] PMX_OFF_BOOT = 8'h44;
  localparam logic [PMX_ADDR_W-1:0] PMX_OFF_CTLA = 8'h48;
  localparam logic [PMX_ADDR_W-1:0] PMX_OFF_CTLB = 8'h4C;

  // ************************************************************
  // Reset values and writable masks
  // ************************************************************
  localparam logic [31:0] PMX_P0_RESET   = 32'h0000_0003;
  localparam logic [31:0] PMX_P1_RESET   = 32'h0000_0000;
  localparam logic [31:0] PMX_P2_RESET   = 32'h0000_0000;
  localparam logic [31:0] PMX_WPC_RESET  = 32'h0000_0000;
  localparam logic [31:0] PMX_BOOT_RESET = 32'h0000_0000;
  localparam logic [31:0] PMX_CTLA_RESET = 32'h0000_0000;
  localparam logic [31:0] PMX_CTLB_RESET = 32'h0004_0004;
  localparam logic [31:0] PMX_P0_MASK    = 32'h00FF_FF03;
  localparam logic [31:0] PMX_P1_MASK    = 32'h00FF_FF3E;
  localparam logic [31:0] PMX_P2_MASK    = 32'h00FF_FF2F;
  localparam logic [31:0] PMX_ZERO       = 32'h0000_0000;

  // Field positions inside a select register
  localparam int PMX_EXT_LSB = 16;
  localparam int PMX_MID_LSB = 8;
  localparam int PMX_LOW_LSB = 0;
  localparam int PMX_PORT_W  = 8;

  localparam logic [2:0] PMX_CODE_GPIO = 3'h0;
  localparam logic       PMX_DI_IDLE   = 1'b1;

  // Legal codes per pin, pin index = port*8+n, bit c set when code c routes
  localparam logic [PMX_PINS-1:0][PMX_CODES-1:0] PMX_VALID_MASK = {
    8'h01, 8'h01, 8'h1F, 8'h4F, 8'hCF, 8'h9F, 8'h9F, 8'h01,
    8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h01, 8'h1F, 8'h1F
  };

  typedef struct packed {
    logic [31:0] p0;
    logic [31:0] p1;
    logic [31:0] p2;
    logic [31:0] wpc;
    logic [31:0] ctla;
    logic [31:0] ctlb;
    logic [31:0] boot;
    logic [31:0] rdata;
    logic        ack;
    logic        live;
  } pmx_regs_t;

  typedef struct packed {
    logic [2:0]           sync;
    logic                 filt;
    logic                 dout;
    logic                 oe_n;
    logic [PMX_CODES-1:0] din;
  } pmx_cell_t;

endpackage

// File: hw/pmx_pin_cell.sv
/*
  One pad's multiplexer cell: picks output data and enable by select code,
  filters the pad input and fans it to the selected function input.
  Assumes code index 0 is the GPIO controller, codes 1..7 peripherals.
*/
`timescale 1ns/1ps
module pmx_pin_cell #(
  parameter logic [pmx_pkg::PMX_CODES-1:0] VALID_MASK = 8'h01
) (
  input  wire logic                          ref_clk,
  input  wire logic                          rst_n,
  input  wire logic [2:0]                    code,
  input  wire logic [pmx_pkg::PMX_CODES-1:0] func_do,
  input  wire logic [pmx_pkg::PMX_CODES-1:0] func_oe_n,
  input  wire logic                          pad_di,
  output logic                               pad_do,
  output logic                               pad_oe_n,
  output logic [pmx_pkg::PMX_CODES-1:0]      func_di
);
  import pmx_pkg::*;

  pmx_cell_t st_reg;
  pmx_cell_t st_next;
  logic [2:0] eff_code;

  // Unlisted or reserved codes fall back to GPIO
  assign eff_code = VALID_MASK[code] ? code : PMX_CODE_GPIO;  // [R16] [R6]

  always_comb begin
    st_next      = st_reg;
    // First stage feeds only the second
    st_next.sync = {st_reg.sync[1:0], pad_di};
    if (st_reg.sync[1] == st_reg.sync[2]) begin
      st_next.filt = st_reg.sync[2];
    end
    st_next.dout = func_do[eff_code];  // [R17]
    st_next.oe_n = func_oe_n[eff_code];
    for (int c = 0; c < PMX_CODES; c++) begin
      st_next.din[c] = (c == int'(eff_code)) ? st_reg.filt : PMX_DI_IDLE;
    end
    // GPIO input always sees the pad so software can read any pin
    st_next.din[0] = st_reg.filt;
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= '{sync: '1, filt: PMX_DI_IDLE, dout: 1'b0, oe_n: 1'b1, din: '1};
    end else begin
      st_reg <= st_next;
    end
  end

  assign pad_do   = st_reg.dout;
  assign pad_oe_n = st_reg.oe_n;
  assign func_di  = st_reg.din;

endmodule // pmx_pin_cell

// File: hw/pmx_pin_mux.sv
/*
  Port pin function multiplexer: system select registers and the per-pad
  routing between pads and on-chip peripheral signals for ports 0 and 1.
  Assumes a simple one-cycle register port on ref_clk; pads are pin index
  port*8+n; the testbench resolves the pad wires from the enables.
*/
`timescale 1ns/1ps
module pmx_pin_mux (
  input  wire logic                                                  ref_clk,
  input  wire logic                                                  rst_n,
  input  wire logic                                                  reg_sel,
  input  wire logic                                                  reg_wr,
  input  wire logic [pmx_pkg::PMX_ADDR_W-1:0]                        reg_addr,
  input  wire logic [31:0]                                           reg_wdata,
  output logic      [31:0]                                           reg_rdata,
  output logic                                                       reg_ack,
  input  wire logic [31:0]                                           boot_state,
  input  wire logic [pmx_pkg::PMX_PINS-1:0][pmx_pkg::PMX_CODES-1:0]  func_do,
  input  wire logic [pmx_pkg::PMX_PINS-1:0][pmx_pkg::PMX_CODES-1:0]  func_oe_n,
  output logic      [pmx_pkg::PMX_PINS-1:0][pmx_pkg::PMX_CODES-1:0]  func_di,
  input  wire logic [pmx_pkg::PMX_PINS-1:0]                          pad_di,
  output logic      [pmx_pkg::PMX_PINS-1:0]                          pad_do,
  output logic      [pmx_pkg::PMX_PINS-1:0]                          pad_oe_n,
  output logic      [31:0]                                           wp_ctrl,
  output logic      [31:0]                                           sys_ctrl_a,
  output logic      [31:0]                                           sys_ctrl_b
);
  import pmx_pkg::*;

  pmx_regs_t st_reg;
  pmx_regs_t st_next;
  logic [PMX_PINS-1:0][2:0] pin_code;

  // ************************************************************
  // Register port
  // ************************************************************
  always_comb begin
    st_next      = st_reg;
    st_next.ack  = 1'b0;
    st_next.live = 1'b1;
    st_next.boot = boot_state;
    if (reg_sel) begin
      st_next.ack = 1'b1;
      if (reg_wr) begin
        // Reserved bits are masked so they never hold a one
        case (reg_addr)
          PMX_OFF_P0:   st_next.p0   = reg_wdata & PMX_P0_MASK;  // [R1] [R9] [R16]
          PMX_OFF_P1:   st_next.p1   = reg_wdata & PMX_P1_MASK;  // [R2] [R15] [R16]
          PMX_OFF_P2:   st_next.p2   = reg_wdata & PMX_P2_MASK;  // [R3] [R5]
          PMX_OFF_WPC:  st_next.wpc  = reg_wdata;                // [R4]
          PMX_OFF_CTLA: st_next.ctla = reg_wdata;
          PMX_OFF_CTLB: st_next.ctlb = reg_wdata;
          default:      st_next.rdata = st_reg.rdata;
        endcase
      end else begin
        case (reg_addr)
          PMX_OFF_P0:   st_next.rdata = st_reg.p0;
          PMX_OFF_P1:   st_next.rdata = st_reg.p1;
          PMX_OFF_P2:   st_next.rdata = st_reg.p2;
          PMX_OFF_WPC:  st_next.rdata = st_reg.wpc;
          PMX_OFF_BOOT: st_next.rdata = st_reg.boot;
          PMX_OFF_CTLA: st_next.rdata = st_reg.ctla;
          PMX_OFF_CTLB: st_next.rdata = st_reg.ctlb;
          default:      st_next.rdata = PMX_ZERO;
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg.p0    <= PMX_P0_RESET;  // [R1]
      st_reg.p1    <= PMX_P1_RESET;  // [R2]
      st_reg.p2    <= PMX_P2_RESET;  // [R3]
      st_reg.wpc   <= PMX_WPC_RESET; // [R4]
      st_reg.ctla  <= PMX_CTLA_RESET;
      st_reg.ctlb  <= PMX_CTLB_RESET;
      st_reg.boot  <= PMX_BOOT_RESET;
      st_reg.rdata <= PMX_ZERO;
      st_reg.ack   <= 1'b0;
      st_reg.live  <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign reg_rdata  = st_reg.rdata;
  assign reg_ack    = st_reg.ack;
  assign wp_ctrl    = st_reg.wpc;
  assign sys_ctrl_a = st_reg.ctla;
  assign sys_ctrl_b = st_reg.ctlb;

  // ************************************************************
  // Per-pad routing
  // ************************************************************
  // Each pad owns its own cell, so a write to one pin's code cannot disturb
  // the routing of any other pad.
  for (genvar g = 0; g < PMX_PINS; g++) begin : g_pin
    localparam int N = g % PMX_PORT_W;
    logic [31:0] sel_word;
    assign sel_word    = (g < PMX_PORT_W) ? st_reg.p0 : st_reg.p1;
    assign pin_code[g] = {sel_word[PMX_EXT_LSB+N],
                          sel_word[PMX_MID_LSB+N],
                          sel_word[PMX_LOW_LSB+N]};  // [R5] [R6]

    // Legal codes per pad carry the function tables of both ports
    pmx_pin_cell #(
      .VALID_MASK (PMX_VALID_MASK[g])  // [R7] [R8] [R10] [R11] [R12] [R13] [R14]
    ) u_cell (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .code      (pin_code[g]),
      .func_do   (func_do[g]),
      .func_oe_n (func_oe_n[g]),
      .pad_di    (pad_di[g]),
      .pad_do    (pad_do[g]),
      .pad_oe_n  (pad_oe_n[g]),
      .func_di   (func_di[g])
    );
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_p1_write;
    reg_sel && reg_wr && (reg_addr == PMX_OFF_P1);
  endsequence

  sequence s_p1_stored;
    st_reg.p1 == ($past(reg_wdata) & PMX_P1_MASK);
  endsequence

  sequence s_wpc_write;
    reg_sel && reg_wr && (reg_addr == PMX_OFF_WPC);
  endsequence

  sequence s_wpc_read;
    reg_sel && !reg_wr && (reg_addr == PMX_OFF_WPC);
  endsequence

  // Pads keep their reset drive until the first edge after release, so
  // routing is only judged once the register port is live
  property p_route(pin, code);
    st_reg.live && (pin_code[pin] == code) |=>
      (pad_do[pin] == $past(func_do[pin][code])) &&
      (pad_oe_n[pin] == $past(func_oe_n[pin][code]));
  endproperty

  property p_gpio(pin, code);
    st_reg.live && (pin_code[pin] == code) |=>
      (pad_do[pin] == $past(func_do[pin][0])) &&
      (pad_oe_n[pin] == $past(func_oe_n[pin][0])) &&
      (func_di[pin][code] == PMX_DI_IDLE);
  endproperty

  a_p0_reset_val: assert property (!st_reg.live |-> st_reg.p0 == PMX_P0_RESET)  // [R1]
    else $error("port 0 select not at reset value");

  a_p1_reset_val: assert property (!st_reg.live |-> st_reg.p1 == PMX_P1_RESET)  // [R2]
    else $error("port 1 select not at reset value");

  a_p2_wpc_reset: assert property (!st_reg.live |->  // [R3] [R4]
                                   (st_reg.p2 == PMX_P2_RESET) && (st_reg.wpc == PMX_WPC_RESET))
    else $error("port 2 or protect control not at reset value");

  a_wpc_readback: assert property (s_wpc_write ##1 !reg_sel ##1 s_wpc_read |=>  // [R4]
                                   reg_ack && reg_rdata == $past(reg_wdata, 3))
    else $error("protect control read back wrong");

  a_reserved_zero: assert property (((st_reg.p0 & ~PMX_P0_MASK) == PMX_ZERO) &&  // [R16]
                                    ((st_reg.p1 & ~PMX_P1_MASK) == PMX_ZERO) &&
                                    ((st_reg.p2 & ~PMX_P2_MASK) == PMX_ZERO))
    else $error("reserved select bit holds a one");

  a_gpio_route: assert property (pin_code[9] == PMX_CODE_GPIO ##1 pin_code[9] == PMX_CODE_GPIO  // [R6]
                                 |-> pad_do[9] == $past(func_do[9][0]))
    else $error("code 000 did not route gpio");

  a_p0_debug_data: assert property (pin_code[1] == 3'h1 |=> pad_do[1] == $past(func_do[1][1]) &&  // [R7]
                                    pad_oe_n[1] == $past(func_oe_n[1][1]))
    else $error("port 0 pin 1 code 001 misrouted");

  a_p0_reserved: assert property (pin_code[0] == 3'h7 |=> pad_do[0] == $past(func_do[0][0]) &&  // [R8] [R16]
                                  func_di[0][7] == PMX_DI_IDLE)
    else $error("reserved code on port 0 pin 0 not gpio");

  a_p1_spi_select: assert property (pin_code[11] == 3'h7 |=> pad_do[11] == $past(func_do[11][7]))  // [R12]
    else $error("port 1 pin 3 code 111 misrouted");

  a_p1_pin4_rsvd: assert property (pin_code[12] == 3'h4 |=> pad_oe_n[12] == $past(func_oe_n[12][0]))  // [R11]
    else $error("unlisted code on port 1 pin 4 not gpio");

  a_p1_write_path: assert property (s_p1_write |=> s_p1_stored ##1  // [R17] [R10]
                                    pad_do[13] == $past(func_do[13][pin_code[13]]) ||
                                    !PMX_VALID_MASK[13][pin_code[13]])
    else $error("port 1 write did not reach pad in time");

  a_p1_pin0_gpio: assert property (1'b1 |=> pad_do[8] == $past(func_do[8][0]))  // [R15]
    else $error("port 1 pin 0 left gpio");

  a_p0_high_gpio: assert property (1'b1 |=> pad_do[7] == $past(func_do[7][0]))  // [R9]
    else $error("port 0 pin 7 left gpio");

  a_slow_clock: assert property (pin_code[9] == 3'h4 |=> pad_do[9] == $past(func_do[9][4]))  // [R14]
    else $error("port 1 pin 1 slow clock misrouted");

  a_uart_tx_p12: assert property (pin_code[10] == 3'h4 |=> pad_do[10] == $past(func_do[10][4]))  // [R13]
    else $error("port 1 pin 2 code 100 misrouted");

  a_read_ack: assert property (st_reg.live |-> reg_ack == $past(reg_sel))  // [R3] [R4]
    else $error("register access not answered in one cycle");

  a_p00_debug_clk: assert property (p_route(0, 3'h1))  // [R8]
    else $error("pin 0.0 code 001 misrouted");

  a_p00_uart_rx: assert property (p_route(0, 3'h2))  // [R8]
    else $error("pin 0.0 code 010 misrouted");

  a_p00_i2c_clk: assert property (p_route(0, 3'h3))  // [R8]
    else $error("pin 0.0 code 011 misrouted");

  a_p00_spi_clk: assert property (p_route(0, 3'h4))  // [R8]
    else $error("pin 0.0 code 100 misrouted");

  a_p00_c5_gpio: assert property (p_gpio(0, 3'h5))  // [R8] [R16]
    else $error("pin 0.0 code 101 not gpio");

  a_p00_c6_gpio: assert property (p_gpio(0, 3'h6))  // [R8] [R16]
    else $error("pin 0.0 code 110 not gpio");

  a_p01_uart_tx: assert property (p_route(1, 3'h2))  // [R7]
    else $error("pin 0.1 code 010 misrouted");

  a_p01_i2c_data: assert property (p_route(1, 3'h3))  // [R7]
    else $error("pin 0.1 code 011 misrouted");

  a_p01_spi_sel: assert property (p_route(1, 3'h4))  // [R7]
    else $error("pin 0.1 code 100 misrouted");

  a_p01_c5_gpio: assert property (p_gpio(1, 3'h5))  // [R7] [R16]
    else $error("pin 0.1 code 101 not gpio");

  a_p01_c6_gpio: assert property (p_gpio(1, 3'h6))  // [R7] [R16]
    else $error("pin 0.1 code 110 not gpio");

  a_p01_c7_gpio: assert property (p_gpio(1, 3'h7))  // [R7] [R16]
    else $error("pin 0.1 code 111 not gpio");

  a_p11_uart_rts: assert property (p_route(9, 3'h1))  // [R14]
    else $error("pin 1.1 code 001 misrouted");

  a_p11_spi_mosi: assert property (p_route(9, 3'h2))  // [R14]
    else $error("pin 1.1 code 010 misrouted");

  a_p11_pwm_seven: assert property (p_route(9, 3'h3))  // [R14]
    else $error("pin 1.1 code 011 misrouted");

  a_p11_uart_tx: assert property (p_route(9, 3'h7))  // [R14]
    else $error("pin 1.1 code 111 misrouted");

  a_p11_c5_gpio: assert property (p_gpio(9, 3'h5))  // [R14] [R16]
    else $error("pin 1.1 code 101 not gpio");

  a_p11_c6_gpio: assert property (p_gpio(9, 3'h6))  // [R14] [R16]
    else $error("pin 1.1 code 110 not gpio");

  a_p12_uart_rx: assert property (p_route(10, 3'h1))  // [R13]
    else $error("pin 1.2 code 001 misrouted");

  a_p12_pwm_four: assert property (p_route(10, 3'h2))  // [R13]
    else $error("pin 1.2 code 010 misrouted");

  a_p12_timer_out: assert property (p_route(10, 3'h3))  // [R13]
    else $error("pin 1.2 code 011 misrouted");

  a_p12_spi_miso: assert property (p_route(10, 3'h7))  // [R13]
    else $error("pin 1.2 code 111 misrouted");

  a_p12_c5_gpio: assert property (p_gpio(10, 3'h5))  // [R13] [R16]
    else $error("pin 1.2 code 101 not gpio");

  a_p12_c6_gpio: assert property (p_gpio(10, 3'h6))  // [R13] [R16]
    else $error("pin 1.2 code 110 not gpio");

  a_p13_uart_rts: assert property (p_route(11, 3'h1))  // [R12]
    else $error("pin 1.3 code 001 misrouted");

  a_p13_i2c_data: assert property (p_route(11, 3'h2))  // [R12]
    else $error("pin 1.3 code 010 misrouted");

  a_p13_pwm_three: assert property (p_route(11, 3'h3))  // [R12]
    else $error("pin 1.3 code 011 misrouted");

  a_p13_spi2_sel: assert property (p_route(11, 3'h6))  // [R12]
    else $error("pin 1.3 code 110 misrouted");

  a_p13_c4_gpio: assert property (p_gpio(11, 3'h4))  // [R12] [R16]
    else $error("pin 1.3 code 100 not gpio");

  a_p13_c5_gpio: assert property (p_gpio(11, 3'h5))  // [R12] [R16]
    else $error("pin 1.3 code 101 not gpio");

  a_p14_uart_cts: assert property (p_route(12, 3'h1))  // [R11]
    else $error("pin 1.4 code 001 misrouted");

  a_p14_i2c_clk: assert property (p_route(12, 3'h2))  // [R11]
    else $error("pin 1.4 code 010 misrouted");

  a_p14_pwm_two: assert property (p_route(12, 3'h3))  // [R11]
    else $error("pin 1.4 code 011 misrouted");

  a_p14_spi_clk: assert property (p_route(12, 3'h6))  // [R11]
    else $error("pin 1.4 code 110 misrouted");

  a_p14_c5_gpio: assert property (p_gpio(12, 3'h5))  // [R11] [R16]
    else $error("pin 1.4 code 101 not gpio");

  a_p14_c7_gpio: assert property (p_gpio(12, 3'h7))  // [R11] [R16]
    else $error("pin 1.4 code 111 not gpio");

  a_p15_spi_sel: assert property (p_route(13, 3'h1))  // [R10]
    else $error("pin 1.5 code 001 misrouted");

  a_p15_pwm_five: assert property (p_route(13, 3'h2))  // [R10]
    else $error("pin 1.5 code 010 misrouted");

  a_p15_timer_in: assert property (p_route(13, 3'h3))  // [R10]
    else $error("pin 1.5 code 011 misrouted");

  a_p15_uart_rx: assert property (p_route(13, 3'h4))  // [R10]
    else $error("pin 1.5 code 100 misrouted");

  a_p15_c5_gpio: assert property (p_gpio(13, 3'h5))  // [R10] [R16]
    else $error("pin 1.5 code 101 not gpio");

  a_p15_c6_gpio: assert property (p_gpio(13, 3'h6))  // [R10] [R16]
    else $error("pin 1.5 code 110 not gpio");

  a_p15_c7_gpio: assert property (p_gpio(13, 3'h7))  // [R10] [R16]
    else $error("pin 1.5 code 111 not gpio");

endmodule // pmx_pin_mux

// File: verif/pmx_pad_model.sv
/*
  Board-side model of the pads of the port pin function multiplexer.
  Assumes the bench sets the level each pad sees from the board while no one
  drives it; a pad the mux drives reads back its own output level.
*/
`timescale 1ns/1ps
module pmx_pad_model (
  input  wire logic [pmx_pkg::PMX_PINS-1:0] pad_do,
  input  wire logic [pmx_pkg::PMX_PINS-1:0] pad_oe_n,
  input  wire logic [pmx_pkg::PMX_PINS-1:0] ext_level,
  output logic      [pmx_pkg::PMX_PINS-1:0] pad_di
);
  import pmx_pkg::*;
  // ************************************************************
  // Pad resolution
  // ************************************************************
  // A released pad must not keep the last driven level, so it falls to the board level
  always_comb begin
    for (int i = 0; i < PMX_PINS; i++) begin
      pad_di[i] = pad_oe_n[i] ? ext_level[i] : pad_do[i];
    end
  end
endmodule // pmx_pad_model

// File: verif/pmx_pin_mux_tb_top.sv
/*
  Self-checking bench of the port pin function multiplexer: register access,
  reset values, reserved bits and per-pin routing of every select code.
  Assumes the one-cycle sel/wr/addr register port and a 125 MHz clock.
*/
`timescale 1ns/1ps
module pmx_pin_mux_tb_top;
  import pmx_pkg::*;
  logic                               ref_clk    = 1'b0;
  logic                               rst_n      = 1'b0;
  logic                               reg_sel    = 1'b0;
  logic                               reg_wr     = 1'b0;
  logic [PMX_ADDR_W-1:0]              reg_addr   = '0;
  logic [31:0]                        reg_wdata  = '0;
  logic [31:0]                        boot_state = '0;
  logic [PMX_PINS-1:0][PMX_CODES-1:0] func_do    = '0;
  logic [PMX_PINS-1:0][PMX_CODES-1:0] func_oe_n  = '1;
  logic [PMX_PINS-1:0]                ext_level  = '0;
  logic [PMX_PINS-1:0][PMX_CODES-1:0] func_di;
  logic [PMX_PINS-1:0]                pad_di, pad_do, pad_oe_n;
  logic [31:0]                        reg_rdata, wp_ctrl, sys_ctrl_a, sys_ctrl_b, rd;
  logic                               reg_ack;
  logic [7:0]                         offs [7]  = '{8'h00, 8'h04, 8'h08, 8'h40, 8'h44, 8'h48, 8'h4C};
  logic [31:0]                        rst_v [7] = '{32'h0000_0003, 32'h0000_0000, 32'h0000_0000,
                                                    32'h0000_0000, 32'h0000_0000, 32'h0000_0000,
                                                    32'h0004_0004};
  int                                 pins [9]  = '{0, 1, 2, 8, 9, 10, 11, 12, 13};
  int                                 errors    = 0;
  int                                 compares  = 0;
  int                                 cycles    = 0;

  always #4 ref_clk = ~ref_clk;

  pmx_pin_mux dut_u (.ref_clk(ref_clk), .rst_n(rst_n), .reg_sel(reg_sel), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_ack(reg_ack),
    .boot_state(boot_state), .func_do(func_do), .func_oe_n(func_oe_n), .func_di(func_di),
    .pad_di(pad_di), .pad_do(pad_do), .pad_oe_n(pad_oe_n), .wp_ctrl(wp_ctrl),
    .sys_ctrl_a(sys_ctrl_a), .sys_ctrl_b(sys_ctrl_b));
  pmx_pad_model pad_u (.pad_do(pad_do), .pad_oe_n(pad_oe_n), .ext_level(ext_level), .pad_di(pad_di));

  // ************************************************************
  // Reporting
  // ************************************************************
  task automatic complete_run();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Whole run needs about 870 cycles
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      errors++;
      complete_run();
    end
  end

  // ************************************************************
  // Register port
  // ************************************************************
  // The port takes one access per sampled edge, so sel drops right after it is taken
  task automatic access(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    @(posedge ref_clk);
    reg_sel   <= 1'b1;
    reg_wr    <= wr;
    reg_addr  <= addr;
    reg_wdata <= wd;
    @(posedge ref_clk);
    reg_sel <= 1'b0;
    #1;
    cmp("reg_ack", 32'h1, 32'(reg_ack));
    rd = reg_rdata;
  endtask

  task automatic rd_chk(input logic [7:0] addr, input logic [31:0] exp);
    access(1'b0, addr, 32'h0);
    cmp($sformatf("register %h", addr), exp, rd);
  endtask

  task automatic reset_dut();
    @(posedge ref_clk);
    rst_n      <= 1'b0;
    boot_state <= '0;
    repeat (5) @(posedge ref_clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 7; i++) begin
      rd_chk(offs[i], rst_v[i]);
    end
  endtask

  // ************************************************************
  // Routing
  // ************************************************************
  function automatic logic legal(input int p, input int c);
    logic [7:0] m;
    case (p)
      0, 1, 13: m = 8'h1F;
      9, 10:    m = 8'h9F;
      11:       m = 8'hCF;
      12:       m = 8'h4F;
      default:  m = 8'h01;
    endcase
    return m[c];
  endfunction

  task automatic route_chk(input int p, input int c);
    logic [PMX_PINS-1:0][PMX_CODES-1:0] one;
    logic [31:0]                        word;
    logic [15:0]                        bit_p;
    logic                               ok;
    logic [15:0]                        oe_exp;
    logic [7:0]                         di_exp;
    one       = '0;
    one[p][c] = 1'b1;
    ok        = legal(p, c);
    bit_p     = 16'h1 << p;
    // Sized first so the casts below only zero-extend
    oe_exp    = ok ? ~bit_p : 16'hFFFF;
    di_exp    = ~(8'h01 | (ok ? 8'h01 << c : 8'h00));
    word      = (32'(c[2]) << (16 + p % 8)) | (32'(c[1]) << (8 + p % 8)) | (32'(c[0]) << (p % 8));
    @(posedge ref_clk);
    func_do   <= one;
    func_oe_n <= ~one;
    access(1'b1, (p < 8) ? 8'h00 : 8'h04, word);
    @(posedge ref_clk);
    #1;
    cmp("pad_do", 32'(ok ? bit_p : 16'h0), 32'(pad_do));
    cmp("pad_oe_n", 32'(oe_exp), 32'(pad_oe_n));
    // Released pad reads the board low level through the input filter
    @(posedge ref_clk);
    func_oe_n <= '1;
    repeat (6) @(posedge ref_clk);
    #1;
    cmp("func_di", 32'(di_exp), 32'(func_di[p]));
  endtask

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    reset_dut();
    access(1'b1, 8'h00, '1);
    rd_chk(8'h00, 32'h00FF_FF03);
    access(1'b1, 8'h04, '1);
    rd_chk(8'h04, 32'h00FF_FF3E);
    access(1'b1, 8'h08, '1);
    rd_chk(8'h08, 32'h00FF_FF2F);
    for (int i = 5; i < 7; i++) begin
      access(1'b1, offs[i], 32'h1234_5678 ^ 32'(i));
      rd_chk(offs[i], 32'h1234_5678 ^ 32'(i));
    end
    access(1'b1, 8'h40, 32'h8765_4321);
    rd_chk(8'h40, 32'h8765_4321);
    cmp("wp_ctrl", 32'h8765_4321, wp_ctrl);
    cmp("sys_ctrl_a", 32'h1234_567D, sys_ctrl_a);
    cmp("sys_ctrl_b", 32'h1234_567E, sys_ctrl_b);
    // Read-only status ignores writes and shows the live state
    @(posedge ref_clk);
    boot_state <= 32'hA5A5_0F0F;
    access(1'b1, 8'h44, 32'h0);
    rd_chk(8'h44, 32'hA5A5_0F0F);
    access(1'b1, 8'h10, '1);
    rd_chk(8'h10, 32'h0);
    foreach (pins[k]) begin
      for (int c = 0; c < 8; c++) begin
        route_chk(pins[k], c);
      end
    end
    reset_dut();
    complete_run();
  end
endmodule // pmx_pin_mux_tb_top
